// *** core/lintrx_params.svh ***
// Purpose: timing constants of the LIN transceiver mode control
// Assumes: system clock of 20 MHz
// Notes: least times round up to whole cycles
`ifndef LINTRX_PARAMS_SVH
`define LINTRX_PARAMS_SVH

`define LINTRX_CLK_NS 50
`define LINTRX_BIT_RATE_BPS 20000
`define LINTRX_CNT_W 12
`define LINTRX_EN_FILT_NS 20000
`define LINTRX_DIS_FILT_NS 20000
`define LINTRX_WAKE_DOM_NS 70000
`define LINTRX_STB_DLY_NS 10000
`define LINTRX_EN_FILT_CYC \
    ((`LINTRX_EN_FILT_NS + `LINTRX_CLK_NS - 1) / `LINTRX_CLK_NS)
`define LINTRX_DIS_FILT_CYC \
    ((`LINTRX_DIS_FILT_NS + `LINTRX_CLK_NS - 1) / `LINTRX_CLK_NS)
`define LINTRX_WAKE_DOM_CYC \
    ((`LINTRX_WAKE_DOM_NS + `LINTRX_CLK_NS - 1) / `LINTRX_CLK_NS)
`define LINTRX_STB_DLY_CYC \
    ((`LINTRX_STB_DLY_NS + `LINTRX_CLK_NS - 1) / `LINTRX_CLK_NS)

`endif

// *** core/lintrx_pkg.sv ***
// Purpose: types shared by the LIN transceiver mode control
// Assumes: nothing
// Notes: mode codes are one-hot
package lintrx_pkg;

    typedef enum logic [3:0]
    {
        LINTRX_UNPOWERED = 4'h1,
        LINTRX_SLEEP = 4'h2,
        LINTRX_STANDBY = 4'h4,
        LINTRX_NORMAL = 4'h8
    } lintrx_mode_t;

    // Output enables of the pins; each pin is driven low when enabled
    typedef struct packed
    {
        logic lin_oe;
        logic rxd_oe;
        logic txd_pd_strong;
    } lintrx_pins_t;

endpackage : lintrx_pkg

// *** core/lintrx_filter.sv ***
// Purpose: level filter, done once a level held for CYC cycles
// Assumes: level synchronous to the clock
// Notes: any opposite level or inactive cycle restarts the count
`timescale 1ns/1ps
`include "lintrx_params.svh"
module lintrx_filter #(
    parameter int unsigned CYC = 1
)
(
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    input wire logic i_ce,
    input wire logic i_active,
    input wire logic i_level,
    output logic o_done
);
    import lintrx_pkg::*;

    localparam logic [`LINTRX_CNT_W-1:0] LIMIT = `LINTRX_CNT_W'(CYC);

    logic [`LINTRX_CNT_W-1:0] cnt_r;

    always_ff @(posedge i_clk_sys or negedge i_rst_n)
    begin
        if (!i_rst_n)
            cnt_r <= '0;
        else if (i_ce)
        begin
            if (!i_active || !i_level)
                cnt_r <= '0;
            else if (cnt_r != LIMIT)
                cnt_r <= cnt_r + 1'b1;
        end
    end

    assign o_done = (cnt_r == LIMIT);

    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (!i_rst_n);

    AST_FILT_RESTART: assert property (
        (i_ce && i_active && !i_level) |=> (cnt_r == '0) && !o_done)
        else $error("filter did not restart on glitch");

endmodule : lintrx_filter

// *** core/lintrx_txgate.sv ***
// Purpose: transmit permission from thermal and battery monitors
// Assumes: monitor flags synchronous to the clock
// Notes: both locks are sticky; a new trip wins over a clear
`timescale 1ns/1ps
module lintrx_txgate
(
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    input wire logic i_ce,
    input wire logic i_normal,
    input wire logic i_txd,
    input wire logic i_thermal_trip,
    input wire logic i_vbb_low,
    input wire logic i_vbb_high,
    output logic o_tx_allow
);
    import lintrx_pkg::*;

    logic therm_lock_r;
    logic batt_lock_r;

    // Waiting for a high TxD avoids thermal oscillation on a shorted bus
    always_ff @(posedge i_clk_sys or negedge i_rst_n)
    begin
        if (!i_rst_n)
            therm_lock_r <= 1'b0;
        else if (i_ce)
        begin
            if (i_thermal_trip)
                therm_lock_r <= 1'b1;
            else if (i_txd)
                therm_lock_r <= 1'b0;
        end
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_n)
    begin
        if (!i_rst_n)
            batt_lock_r <= 1'b0;
        else if (i_ce)
        begin
            if (i_normal && i_vbb_low)
                batt_lock_r <= 1'b1;
            else if (i_vbb_high)
                batt_lock_r <= 1'b0;
        end
    end

    assign o_tx_allow = !therm_lock_r && !i_thermal_trip
        && !batt_lock_r && !(i_normal && i_vbb_low);

    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (!i_rst_n);

    AST_THERM_HOLD: assert property (
        (i_ce && i_thermal_trip) ##1 (!i_txd && i_ce)
        |=> !o_tx_allow)
        else $error("transmit re-enabled before high TxD");

    AST_BATT_HYST: assert property (
        (i_ce && i_normal && i_vbb_low) ##1 (!i_vbb_high)
        |-> !o_tx_allow)
        else $error("transmit re-enabled before supply high");

endmodule : lintrx_txgate

// *** core/lintrx_mode_ctrl.sv ***
// Purpose: mode sequencing and transmit gating of a LIN transceiver
// Assumes: i_rst_n is the supply power-on reset; pins synchronous
// Notes: pin outputs are registered, one cycle behind their causes
// Notes on behaviour
// - Normal mode drives bus from transmit input
// - Normal mode receive output follows bus dominant
// - Over-temperature forces bus recessive
// - After cooling, wait for high transmit input
// - Low battery in Normal blocks transmitter
// - Battery block clears at monitor high level
// - Battery block keeps Normal mode and reception
// - Normal entered after enable held high
// - Standby: enable rise releases receive, weak pull-down
// - Reset release enters Sleep, pins released
// - Normal to Sleep after enable held low
// - Sleep leaves bus and receive undriven
// - Sleep to Standby only on bus wake-up
// - Standby holds receive low as wake flag
// - Enable-high filter between 11 and 55 us
// - Enable-low filter between 11 and 55 us
// - Wake needs dominant 40 to 150 us
// - Standby about 10 us after wake ends
`timescale 1ns/1ps
`include "lintrx_params.svh"
module lintrx_mode_ctrl
(
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    input wire logic i_ce,
    input wire logic i_en,
    input wire logic i_txd,
    input wire logic i_lin,
    input wire logic i_thermal_trip,
    input wire logic i_vbb_low,
    input wire logic i_vbb_high,
    output lintrx_pkg::lintrx_mode_t o_mode,
    output lintrx_pkg::lintrx_pins_t o_pins
);
    import lintrx_pkg::*;

    lintrx_mode_t mode_r;
    lintrx_mode_t mode_nxt;
    lintrx_pins_t pins_r;
    lintrx_pins_t pins_nxt;
    logic wake_seen_r;
    logic is_sleep;
    logic is_standby;
    logic is_normal;
    logic en_hi_done;
    logic en_lo_done;
    logic wake_done;
    logic stb_dly_done;
    logic tx_allow;

    assign is_sleep = (mode_r == LINTRX_SLEEP);
    assign is_standby = (mode_r == LINTRX_STANDBY);
    assign is_normal = (mode_r == LINTRX_NORMAL);

    // Enable high before Normal; typical value sits inside the window
    lintrx_filter #(
        .CYC(`LINTRX_EN_FILT_CYC)
    ) u_en_hi (
        .i_clk_sys(i_clk_sys),
        .i_rst_n(i_rst_n),
        .i_ce(i_ce),
        .i_active(is_sleep || is_standby),
        .i_level(i_en),
        .o_done(en_hi_done)
    );

    lintrx_filter #(
        .CYC(`LINTRX_DIS_FILT_CYC)
    ) u_en_lo (
        .i_clk_sys(i_clk_sys),
        .i_rst_n(i_rst_n),
        .i_ce(i_ce),
        .i_active(is_normal),
        .i_level(!i_en),
        .o_done(en_lo_done)
    );

    // Bus low (dominant) long enough counts as a remote wake-up
    lintrx_filter #(
        .CYC(`LINTRX_WAKE_DOM_CYC)
    ) u_wake (
        .i_clk_sys(i_clk_sys),
        .i_rst_n(i_rst_n),
        .i_ce(i_ce),
        .i_active(is_sleep && !wake_seen_r),
        .i_level(!i_lin),
        .o_done(wake_done)
    );

    // Recessive again after the wake pulse, then Standby
    lintrx_filter #(
        .CYC(`LINTRX_STB_DLY_CYC)
    ) u_stb_dly (
        .i_clk_sys(i_clk_sys),
        .i_rst_n(i_rst_n),
        .i_ce(i_ce),
        .i_active(is_sleep && wake_seen_r),
        .i_level(i_lin),
        .o_done(stb_dly_done)
    );

    lintrx_txgate u_txgate (
        .i_clk_sys(i_clk_sys),
        .i_rst_n(i_rst_n),
        .i_ce(i_ce),
        .i_normal(is_normal),
        .i_txd(i_txd),
        .i_thermal_trip(i_thermal_trip),
        .i_vbb_low(i_vbb_low),
        .i_vbb_high(i_vbb_high),
        .o_tx_allow(tx_allow)
    );

    always_comb
    begin
        mode_nxt = mode_r;
        unique case (mode_r)
            LINTRX_UNPOWERED:
                mode_nxt = LINTRX_SLEEP;
            LINTRX_SLEEP:
            begin
                if (en_hi_done)
                    mode_nxt = LINTRX_NORMAL;
                else if (wake_seen_r && stb_dly_done)
                    mode_nxt = LINTRX_STANDBY;
            end
            LINTRX_STANDBY:
            begin
                if (en_hi_done)
                    mode_nxt = LINTRX_NORMAL;
            end
            LINTRX_NORMAL:
            begin
                // Battery block has no say here; mode stays Normal
                if (en_lo_done)
                    mode_nxt = LINTRX_SLEEP;
            end
        endcase
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_n)
    begin
        if (!i_rst_n)
            mode_r <= LINTRX_UNPOWERED;
        else if (i_ce)
            mode_r <= mode_nxt;
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_n)
    begin
        if (!i_rst_n)
            wake_seen_r <= 1'b0;
        else if (i_ce)
        begin
            if (!is_sleep)
                wake_seen_r <= 1'b0;
            else if (wake_done)
                wake_seen_r <= 1'b1;
        end
    end

    // A low TxD means dominant; the controller keeps it high otherwise
    always_comb
    begin
        pins_nxt.lin_oe = is_normal && tx_allow && !i_txd;
        if (is_normal)
            pins_nxt.rxd_oe = !i_lin;
        else
            pins_nxt.rxd_oe = is_standby && !i_en;
        pins_nxt.txd_pd_strong = is_standby && !i_en;
    end

    always_ff @(posedge i_clk_sys or negedge i_rst_n)
    begin
        if (!i_rst_n)
            pins_r <= '0;
        else if (i_ce)
            pins_r <= pins_nxt;
    end

    assign o_mode = mode_r;
    assign o_pins = pins_r;

    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (!i_rst_n);

    sequence s_enter_normal;
        !is_normal ##1 is_normal;
    endsequence

    sequence s_enter_standby;
        !is_standby ##1 is_standby;
    endsequence

    AST_TX_DRIVE: assert property (
        (i_ce && is_normal && tx_allow) |=> o_pins.lin_oe == !$past(i_txd))
        else $error("bus drive does not follow TxD");

    AST_RX_FOLLOWS: assert property (
        (i_ce && is_normal) |=> o_pins.rxd_oe == !$past(i_lin))
        else $error("receive output does not follow bus");

    AST_THERM_OFF: assert property (
        (i_ce && i_thermal_trip) |=> !o_pins.lin_oe)
        else $error("bus driven during over-temperature");

    AST_BATT_OFF: assert property (
        (i_ce && is_normal && i_vbb_low) |=> !o_pins.lin_oe)
        else $error("bus driven with low battery");

    // Enable-low filter already expired may still end Normal here
    AST_BATT_MODE: assert property (
        (i_ce && is_normal && i_en && i_vbb_low && !en_lo_done)
        |=> is_normal)
        else $error("battery block changed the mode");

    AST_ENTER_NORMAL: assert property (
        s_enter_normal |-> $past(en_hi_done) && $past(i_en, 2))
        else $error("Normal entered without enable filter");

    AST_STBY_RELEASE: assert property (
        (i_ce && is_standby && i_en)
        |=> !o_pins.rxd_oe && !o_pins.txd_pd_strong)
        else $error("Standby pins not released on enable");

    AST_POR_SLEEP: assert property (
        (i_ce && mode_r == LINTRX_UNPOWERED) |=> is_sleep
        ##1 (!o_pins.rxd_oe && !o_pins.txd_pd_strong))
        else $error("reset release did not enter Sleep");

    AST_LEAVE_NORMAL: assert property (
        (is_normal ##1 !is_normal) |-> is_sleep && $past(!i_en, 2))
        else $error("Normal left without enable low filter");

    AST_SLEEP_QUIET: assert property (
        (i_ce && is_sleep) |=> !o_pins.lin_oe && !o_pins.rxd_oe)
        else $error("pins driven in Sleep");

    AST_WAKE_ONLY: assert property (
        s_enter_standby |-> $past(is_sleep) && $past(wake_seen_r))
        else $error("Standby entered without wake-up");

    AST_STBY_FLAG: assert property (
        (i_ce && is_standby && !i_en) |=> o_pins.rxd_oe)
        else $error("wake flag not shown in Standby");

endmodule : lintrx_mode_ctrl

// *** testbench/lintrx_ctl_model.sv ***
// Purpose: controller model on the logic side of the transceiver
// Assumes: driven from the same clock as the transceiver
// Notes: enable stays raised once a wake flag was answered, while auto wake is set
`timescale 1ns/1ps
module lintrx_ctl_model
(
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    input wire logic i_wake_flag,
    input wire logic i_auto_wake,
    input wire logic i_en_cmd,
    input wire logic i_dom_cmd,
    output logic o_en,
    output logic o_txd
);
    always_ff @(posedge i_clk_sys or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            o_en <= 1'b0;
            o_txd <= 1'b1;
        end
        else
        begin
            o_en <= i_en_cmd | (i_auto_wake & (i_wake_flag | o_en));
            // High whenever recessive is wanted, never left low
            o_txd <= ~i_dom_cmd;
        end
    end
endmodule : lintrx_ctl_model

// *** testbench/tb_top.sv ***
// Purpose: self-checking bench of the transceiver mode control
// Assumes: clock enable held high throughout
// Notes: bus is a wired-and of the bench node and the design
`timescale 1ns/1ps
module tb_top;
    import lintrx_pkg::*;
    logic clk, rst_n, ctl_rst_n, en, txd, bus, trip, vlow, vhigh, lin;
    logic auto_wake, en_cmd, dom_cmd;
    lintrx_mode_t mode;
    lintrx_pins_t pins;
    int fails = 0;
    int num_checks = 0;
    int cyc = 0;

    assign lin = bus & ~pins.lin_oe;

    lintrx_mode_ctrl i_dut (.i_clk_sys(clk), .i_rst_n(rst_n), .i_ce(1'b1),
        .i_en(en), .i_txd(txd), .i_lin(lin), .i_thermal_trip(trip),
        .i_vbb_low(vlow), .i_vbb_high(vhigh), .o_mode(mode), .o_pins(pins));

    lintrx_ctl_model i_ctl (.i_clk_sys(clk), .i_rst_n(ctl_rst_n),
        .i_wake_flag(pins.rxd_oe), .i_auto_wake(auto_wake),
        .i_en_cmd(en_cmd), .i_dom_cmd(dom_cmd), .o_en(en), .o_txd(txd));

    initial
    begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // Whole run is near 4250 cycles
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            fails++;
            complete_run();
        end
    end

    task automatic complete_run;
        if (fails == 0 && num_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : complete_run

    task automatic step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : step

    task automatic chk_bit(input logic got, input logic exp);
        num_checks++;
        if (got !== exp)
        begin
            fails++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk_bit

    task automatic chk_mode(input lintrx_mode_t got, input lintrx_mode_t exp);
        num_checks++;
        if (got !== exp)
        begin
            fails++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk_mode

    task automatic t_reset;
        step(1);
        chk_mode(mode, LINTRX_UNPOWERED);
        chk_bit(pins.lin_oe, 1'b0);
        @(posedge clk);
        rst_n <= 1'b1;
        ctl_rst_n <= 1'b1;
        step(3);
        chk_mode(mode, LINTRX_SLEEP);
        chk_bit(pins.rxd_oe, 1'b0);
        chk_bit(pins.txd_pd_strong, 1'b0);
    endtask : t_reset

    task automatic t_wake;
        @(posedge clk);
        dom_cmd <= 1'b1;
        bus <= 1'b0;
        step(4);
        chk_bit(pins.lin_oe, 1'b0);
        chk_bit(pins.rxd_oe, 1'b0);
        step(696);
        bus <= 1'b1;
        dom_cmd <= 1'b0;
        step(300);
        chk_mode(mode, LINTRX_SLEEP);
        bus <= 1'b0;
        step(1450);
        bus <= 1'b1;
        step(100);
        chk_mode(mode, LINTRX_SLEEP);
        step(130);
        chk_mode(mode, LINTRX_STANDBY);
        chk_bit(pins.rxd_oe, 1'b1);
        chk_bit(pins.txd_pd_strong, 1'b1);
    endtask : t_wake

    task automatic t_enable;
        auto_wake <= 1'b1;
        step(4);
        chk_bit(pins.rxd_oe, 1'b0);
        chk_bit(pins.txd_pd_strong, 1'b0);
        chk_mode(mode, LINTRX_STANDBY);
        step(216);
        chk_mode(mode, LINTRX_STANDBY);
        step(200);
        chk_mode(mode, LINTRX_NORMAL);
        en_cmd <= 1'b1;
        auto_wake <= 1'b0;
    endtask : t_enable

    task automatic t_normal;
        dom_cmd <= 1'b1;
        step(4);
        chk_bit(pins.lin_oe, 1'b1);
        chk_bit(pins.rxd_oe, 1'b1);
        dom_cmd <= 1'b0;
        step(4);
        chk_bit(pins.lin_oe, 1'b0);
        chk_bit(pins.rxd_oe, 1'b0);
        bus <= 1'b0;
        step(3);
        chk_bit(pins.rxd_oe, 1'b1);
        bus <= 1'b1;
    endtask : t_normal

    task automatic t_thermal;
        trip <= 1'b1;
        dom_cmd <= 1'b1;
        step(4);
        chk_bit(pins.lin_oe, 1'b0);
        trip <= 1'b0;
        step(4);
        chk_bit(pins.lin_oe, 1'b0);
        dom_cmd <= 1'b0;
        step(4);
        dom_cmd <= 1'b1;
        step(5);
        chk_bit(pins.lin_oe, 1'b1);
    endtask : t_thermal

    task automatic t_battery;
        vlow <= 1'b1;
        step(3);
        chk_bit(pins.lin_oe, 1'b0);
        chk_mode(mode, LINTRX_NORMAL);
        bus <= 1'b0;
        step(3);
        chk_bit(pins.rxd_oe, 1'b1);
        bus <= 1'b1;
        vlow <= 1'b0;
        step(4);
        chk_bit(pins.lin_oe, 1'b0);
        vhigh <= 1'b1;
        step(1);
        vhigh <= 1'b0;
        step(3);
        chk_bit(pins.lin_oe, 1'b1);
    endtask : t_battery

    task automatic t_por;
        rst_n <= 1'b0;
        step(1);
        chk_mode(mode, LINTRX_UNPOWERED);
        chk_bit(pins.lin_oe, 1'b0);
        rst_n <= 1'b1;
        step(3);
        chk_mode(mode, LINTRX_SLEEP);
        chk_bit(pins.lin_oe, 1'b0);
        step(440);
        chk_mode(mode, LINTRX_NORMAL);
        chk_bit(pins.lin_oe, 1'b1);
    endtask : t_por

    task automatic t_disable;
        en_cmd <= 1'b0;
        step(200);
        en_cmd <= 1'b1;
        step(3);
        en_cmd <= 1'b0;
        step(210);
        chk_mode(mode, LINTRX_NORMAL);
        step(240);
        chk_mode(mode, LINTRX_SLEEP);
        chk_bit(pins.lin_oe, 1'b0);
    endtask : t_disable

    initial
    begin
        rst_n = 1'b0;
        ctl_rst_n = 1'b0;
        trip = 1'b0;
        vlow = 1'b0;
        vhigh = 1'b0;
        bus = 1'b1;
        auto_wake = 1'b0;
        en_cmd = 1'b0;
        dom_cmd = 1'b0;
        t_reset();
        t_wake();
        t_enable();
        t_normal();
        t_thermal();
        t_battery();
        t_por();
        t_disable();
        complete_run();
    end
endmodule : tb_top
